// ---- spm_pkg.sv ----
package spm_pkg;
    // ------------------------------------------------------------
    // word framing
    // ------------------------------------------------------------
    localparam int unsigned FULL_BITS = 20;
    localparam int unsigned HALF_BITS = 10;
    localparam logic [4:0]  FULL_LAST = 5'h13;
    localparam logic [4:0]  HALF_LAST = 5'h09;
    localparam logic [4:0]  FULL_MID  = 5'h0A;
    localparam logic [4:0]  HALF_MID  = 5'h05;
    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_STAT  = 8'h04;
    localparam logic [7:0]  OFS_RXCNT = 8'h08;
    localparam logic        CODER_RST = 1'h0;
    localparam int unsigned CTRL_CODER = 0;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // 8b/10b tables, codes held abcdei / fghj with a in the msb
    // ------------------------------------------------------------
    localparam logic [5:0] CODE6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] CODE4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] ALT7  = 4'h7;
    localparam logic [5:0] K28_6 = 6'h0F;
    localparam logic [4:0] K28_X = 5'h1C;
    localparam logic [6:0] COMMA_P = 7'h7C;
    localparam logic [6:0] COMMA_N = 7'h03;

    typedef struct packed {
        logic       k;
        logic [7:0] data;
    } spm_sym_t;

    // 6b code complemented under positive disparity
    function automatic logic spm_flip6(input logic [4:0] x);
        return ($countones(CODE6[x]) != 3) || (x == 5'h07);
    endfunction

    // 4b code complemented under positive disparity
    function automatic logic spm_flip4(input logic [2:0] y);
        return (y[1:0] == 2'h0) || (y == 3'h7) || (y == 3'h3);
    endfunction
endpackage

// ---- spm_enc.sv ----
`timescale 1ns/1ns
module spm_enc (
    input  spm_pkg::spm_sym_t sym,
    input  wire logic         rd_in,
    output logic [9:0]        code,
    output logic              rd_out
);
    import spm_pkg::*;
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       alt;
    logic       rd_mid;
    logic [5:0] c6;
    logic [3:0] c4;

    // rd high means positive running disparity
    always_comb
    begin
        x = sym.data[4:0];
        y = sym.data[7:5];
        k28 = sym.k && (x == K28_X);
        c6 = k28 ? K28_6 : CODE6[x];
        if (rd_in && (k28 || spm_flip6(x)))
            c6 = ~c6;
        rd_mid = rd_in ^ (k28 || (spm_flip6(x) && x != 5'h07));
        // alternate x.7 avoids a run of five equal bits
        alt = (y == 3'h7) && (sym.k
            || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
            || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        c4 = alt ? ALT7 : CODE4[y];
        if (rd_mid && spm_flip4(y))
            c4 = ~c4;
        if (k28 && !rd_mid && !spm_flip4(y))
            c4 = ~c4;
        rd_out = rd_mid ^ ((y[1:0] == 2'h0) || (y == 3'h7));
        code = {c6, c4};
    end
endmodule // spm_enc

// ---- spm_dec.sv ----
`timescale 1ns/1ns
module spm_dec (
    input  wire logic [9:0]   code,
    output spm_pkg::spm_sym_t sym
);
    import spm_pkg::*;
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       alt;

    // table search; an unmatched 6b or 4b part decodes to zero without a flag
    always_comb
    begin
        c6 = code[9:4];
        k28 = (c6 == K28_6) || (c6 == ~K28_6);
        c4 = (c6 == ~K28_6) ? ~code[3:0] : code[3:0];
        x = 5'h00;
        y = 3'h0;
        for (int i = 0; i < 32; i++)
            if (CODE6[i] == c6 || (spm_flip6(i[4:0]) && ~CODE6[i] == c6))
                x = i[4:0];
        if (k28)
            x = K28_X;
        for (int j = 0; j < 8; j++)
            if (CODE4[j] == c4 || (spm_flip4(j[2:0]) && ~CODE4[j] == c4))
                y = j[2:0];
        alt = (c4 == ALT7) || (c4 == ~ALT7);
        if (alt)
            y = 3'h7;
        sym.k = k28 || (alt && (x == 5'h17 || x == 5'h1B
            || x == 5'h1D || x == 5'h1E));
        sym.data = {y, x};
    end
endmodule // spm_dec

// ---- spm_top.sv ----
`timescale 1ns/1ns
// Summary of operation
// - transmit word registered on rising edge
// - full rate takes all 20 bits, 18 when coded
// - half rate takes lower half, low byte and bit 16 when coded
// - bypass sends raw 20 or 10 bits
// - coded bytes in 0-7/8-15, K in 16/17
// - coded: two bytes full, one byte half
// - low byte first, lsb first
// - receive word stable at recovered clock rise
// - receive outputs high impedance during reset
// - half rate: lower receive half valid, K in 16 when coded
// - bypass returns raw coded receive words
// - decoded bytes, K status, 18/19 floating
// - decoded: two bytes full, one half
// - first byte low, first bit lsb
// - recovered clock is bit clock over 20/10
// - recovered clock held low in reset
// - transmit rate select high means full rate
// - receive rate select high means full rate
module spm_top (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [19:0] tx_data,
    input  wire logic        transmit_rate_select,
    output logic             tx_word_strobe,
    output logic             tx_serial_out,
    output logic             tx_serial_oe_n,
    input  wire logic        rx_serial_in,
    input  wire logic        receive_rate_select,
    output logic [19:0]      rx_data_out,
    output logic [19:0]      rx_data_oe_n,
    output logic             rx_par_clk
);
    import spm_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // code words are held a-first in the msb, the wire wants a in bit 0
    function automatic logic [9:0] rev10(input logic [9:0] v);
        for (int i = 0; i < 10; i++)
            rev10[i] = v[9 - i];
    endfunction

    // 0 ctrl, 1 status, 2 word count, 3 unmapped
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        unique case (a)
            OFS_CTRL:  reg_sel = 2'h0;
            OFS_STAT:  reg_sel = 2'h1;
            OFS_RXCNT: reg_sel = 2'h2;
            default:   reg_sel = 2'h3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic        aw_hold_q;
    logic [7:0]  awaddr_q;
    logic        w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        coder_en_q;
    logic        do_write;
    logic [1:0]  wsel;
    logic [31:0] rd_mux;
    logic        tx_rd_q;
    logic        rx_aligned_q;
    logic [31:0] rx_count_q;
    logic        tx_full;
    logic        rx_full;

    // one write in flight; holds drop only when the write is done
    assign awready  = !aw_hold_q;
    assign wready   = !w_hold_q;
    assign arready  = !rvalid_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign rvalid   = rvalid_q;
    assign rdata    = rdata_q;
    assign rresp    = rresp_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign wsel     = reg_sel(awaddr_q);

    // address and data channels taken in either order
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
            w_hold_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (awvalid && !aw_hold_q)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            else if (do_write)
                aw_hold_q <= 1'b0;
            if (wvalid && !w_hold_q)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            else if (do_write)
                w_hold_q <= 1'b0;
        end
    end

    // write response; unmapped offsets answer slverr
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wsel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    // coder enable steers both directions at once
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            coder_en_q <= CODER_RST;
        else if (do_write && wsel == 2'h0 && wstrb_q[0])
            coder_en_q <= wdata_q[CTRL_CODER];
    end

    // read data mux, status shows live rate pins and link state
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (reg_sel(araddr))
            2'h0: rd_mux[CTRL_CODER] = coder_en_q;
            2'h1: rd_mux[3:0] = {rx_aligned_q, tx_rd_q, rx_full, tx_full};
            2'h2: rd_mux = rx_count_q;
            2'h3: rd_mux = 32'h0000_0000;
        endcase
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end
        else if (arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= (reg_sel(araddr) == 2'h3) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rready)
            rvalid_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    logic [4:0]  tx_cnt_q;
    logic [4:0]  tx_last;
    logic [19:0] sh_q;
    logic [19:0] txw_d;
    logic        tx_oe_n_q;
    logic [9:0]  code_lo;
    logic [9:0]  code_hi;
    logic        rd_lo;
    logic        rd_hi;
    spm_sym_t    tx_lo;
    spm_sym_t    tx_hi;

    // a floating pin reads high at the pad, so high is full rate
    assign tx_full = transmit_rate_select;
    assign tx_last = tx_full ? FULL_LAST : HALF_LAST;
    // ">=" keeps the word clean when the rate drops mid word
    assign tx_word_strobe = (tx_cnt_q >= tx_last);
    // bits 18 and 19 never reach the coder
    assign tx_lo = '{k: tx_data[16], data: tx_data[7:0]};
    assign tx_hi = '{k: tx_data[17], data: tx_data[15:8]};
    assign tx_serial_out  = sh_q[0];
    assign tx_serial_oe_n = tx_oe_n_q;

    spm_enc u_enc_lo (
        .sym    (tx_lo),
        .rd_in  (tx_rd_q),
        .code   (code_lo),
        .rd_out (rd_lo)
    );

    // high byte picks up the disparity the low byte left
    spm_enc u_enc_hi (
        .sym    (tx_hi),
        .rd_in  (rd_lo),
        .code   (code_hi),
        .rd_out (rd_hi)
    );

    // word to serialize, low byte in the low bits goes first
    always_comb
    begin
        if (coder_en_q)
            txw_d = tx_full ? {rev10(code_hi), rev10(code_lo)}
                            : {10'h000, rev10(code_lo)};
        else
            txw_d = tx_full ? tx_data
                            : {10'h000, tx_data[9:0]};
    end

    // word slot counter
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            tx_cnt_q <= 5'h00;
        else if (tx_word_strobe)
            tx_cnt_q <= 5'h00;
        else
            tx_cnt_q <= tx_cnt_q + 5'h01;
    end

    // latch at the strobe edge, then shift out lsb first
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            sh_q <= 20'h00000;
        else if (tx_word_strobe)
            sh_q <= txw_d;
        else
            sh_q <= {1'b0, sh_q[19:1]};
    end

    // running disparity and serial enable
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_rd_q   <= 1'b0;
            tx_oe_n_q <= 1'b1;
        end
        else
        begin
            tx_oe_n_q <= 1'b0;
            if (tx_word_strobe && coder_en_q)
                tx_rd_q <= tx_full ? rd_hi : rd_lo;
        end
    end

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    logic [19:0] sr_q;
    logic [19:0] sr_d;
    logic [4:0]  rx_cnt_q;
    logic [4:0]  rx_cnt_d;
    logic [4:0]  rx_last;
    logic [4:0]  rx_mid;
    logic [4:0]  eff_cnt;
    logic        comma;
    logic        realign;
    logic        rx_word_done;
    logic        rx_clk_q;
    logic [19:0] rxd_q;
    logic [19:0] rxd_d;
    logic [19:0] rx_oe_n_q;
    logic [9:0]  raw_lo;
    spm_sym_t    rx_lo;
    spm_sym_t    rx_hi;

    assign rx_full = receive_rate_select;
    assign rx_last = rx_full ? FULL_LAST : HALF_LAST;
    assign rx_mid  = rx_full ? FULL_MID : HALF_MID;
    // newest bit enters at the top, so the first bit ends in bit 0
    assign sr_d = {rx_serial_in, sr_q[19:1]};
    // comma only seen as abcdeif of the latest ten bits
    assign comma = coder_en_q
        && (sr_d[16:10] == COMMA_P || sr_d[16:10] == COMMA_N);
    // a high byte comma at full rate is already on the boundary
    assign realign = comma && rx_cnt_q != HALF_LAST && rx_cnt_q != rx_last;
    assign eff_cnt = realign ? HALF_LAST : rx_cnt_q;
    assign rx_word_done = (eff_cnt >= rx_last);
    assign rx_cnt_d = rx_word_done ? 5'h00 : eff_cnt + 5'h01;
    assign raw_lo = rx_full ? sr_d[9:0] : sr_d[19:10];
    assign rx_data_out  = rxd_q;
    assign rx_data_oe_n = rx_oe_n_q;
    assign rx_par_clk   = rx_clk_q;

    spm_dec u_dec_lo (
        .code (rev10(raw_lo)),
        .sym  (rx_lo)
    );

    spm_dec u_dec_hi (
        .code (rev10(sr_d[19:10])),
        .sym  (rx_hi)
    );

    // word assembly for each mode
    always_comb
    begin
        if (coder_en_q)
            rxd_d = rx_full ? {2'h0, rx_hi.k, rx_lo.k, rx_hi.data, rx_lo.data}
                            : {3'h0, rx_lo.k, 8'h00, rx_lo.data};
        else
            rxd_d = rx_full ? sr_d
                            : {10'h000, sr_d[19:10]};
    end

    // shift register and bit counter
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sr_q     <= 20'h00000;
            rx_cnt_q <= 5'h00;
        end
        else
        begin
            sr_q     <= sr_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // clock low from word update to mid word, so data settles first
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rx_clk_q <= 1'b0;
        else
            rx_clk_q <= (rx_cnt_d >= rx_mid);
    end

    // word register changes only while the clock is low
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rxd_q <= 20'h00000;
        else if (rx_word_done)
            rxd_q <= rxd_d;
    end

    // pins float in reset; 18/19 float while decoding
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rx_oe_n_q <= 20'hFFFFF;
        else
            rx_oe_n_q <= coder_en_q ? 20'hC0000 : 20'h00000;
    end

    // alignment flag and word count; comma set beats disable
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_aligned_q <= 1'b0;
            rx_count_q   <= 32'h0000_0000;
        end
        else
        begin
            if (comma)
                rx_aligned_q <= 1'b1;
            else if (!coder_en_q)
                rx_aligned_q <= 1'b0;
            if (rx_word_done)
                rx_count_q <= rx_count_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence lsb_first_s;
        ##1 (tx_serial_out == $past(txw_d[0]))
        ##1 (tx_serial_out == $past(txw_d[1], 2));
    endsequence

    tx_lsb_first_a: assert property (
        tx_word_strobe |-> lsb_first_s)
        else $error("serial order not lsb first");
    tx_slot_gap_a: assert property (
        tx_word_strobe |=> !tx_word_strobe [*8])
        else $error("transmit word slot too short");
    tx_raw_full_a: assert property (
        tx_word_strobe && !coder_en_q && tx_full |=> sh_q == $past(tx_data))
        else $error("raw word not latched whole");
    tx_half_low_a: assert property (
        tx_word_strobe && !tx_full |=> sh_q[19:10] == 10'h000)
        else $error("upper half sent at half rate");
    rx_reset_state_a: assert property (
        $past(reset) |-> rx_data_oe_n == 20'hFFFFF && !rx_par_clk)
        else $error("receive pins driven in reset");
    rx_clk_high_a: assert property (
        $rose(rx_par_clk) |=> rx_par_clk [*4])
        else $error("recovered clock high phase short");
    rx_stable_rise_a: assert property (
        $rose(rx_par_clk) |-> $stable(rxd_q) && $past(!rx_word_done))
        else $error("receive word changed at clock rise");
    rx_bit_order_a: assert property (
        rx_word_done && !coder_en_q && rx_full
        |=> rxd_q[19] == $past(rx_serial_in)
            && rxd_q[18] == $past(rx_serial_in, 2))
        else $error("receive bit order wrong");
    rx_top_float_a: assert property (
        coder_en_q && $past(coder_en_q) |-> rx_data_oe_n[19:18] == 2'h3)
        else $error("bits 18 and 19 driven while decoding");
    rx_half_zero_a: assert property (
        rx_word_done && !rx_full && !coder_en_q |=> rxd_q[19:10] == 10'h000)
        else $error("upper half driven at half rate");
    bus_bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
endmodule // spm_top

// ---- spm_mac_model.sv ----
`timescale 1ns/1ns
// ----
// protocol device model
// ----
module spm_mac_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        tx_word_strobe,
    input  wire logic [19:0] next_word,
    output logic [19:0]      tx_data
);
    // word moves only after the edge that took it, never torn mid-word
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            tx_data <= 20'h00000;
        else if (tx_word_strobe)
            tx_data <= next_word;
    end
endmodule // spm_mac_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    import spm_pkg::*;
    logic        core_clk = 0, reset = 1, txr = 1, rxr = 1, loop = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid, rx_serial_in;
    logic        tx_word_strobe, tx_serial_out, tx_serial_oe_n, rx_par_clk;
    logic [1:0]  bresp, rresp, r;
    logic [19:0] tx_data, next_word = 20'hA5C3E, rx_data_out, rx_data_oe_n, hist;
    logic [22:0] pat = 23'h5A3C9;
    int          fails = 0, checks = 0, cyc = 0;
    // ----
    // clock, stimulus, watchdog
    // ----
    always #5 core_clk = ~core_clk;
    assign rx_serial_in = loop ? tx_serial_out : pat[0];
    // history of sampled serial bits, first sampled ends in bit 0
    always @(posedge core_clk)
    begin
        pat <= {pat[0], pat[22:1]};
        hist <= {rx_serial_in, hist[19:1]};
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            finish_test();
        end
    end
    spm_top DUT (.core_clk, .reset, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_data,
        .transmit_rate_select(txr), .tx_word_strobe, .tx_serial_out, .tx_serial_oe_n,
        .rx_serial_in, .receive_rate_select(rxr), .rx_data_out, .rx_data_oe_n, .rx_par_clk);
    spm_mac_model MAC (.core_clk, .reset, .tx_word_strobe, .next_word, .tx_data);
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ad, wd;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        #1;
        // readies read settled; the next edge is the one that takes
        while (awvalid || wvalid)
        begin
            ad = awvalid && awready === 1'b1;
            wd = wvalid && wready === 1'b1;
            @(posedge core_clk);
            if (ad)
                awvalid <= 0;
            if (wd)
                wvalid <= 0;
            #1;
        end
        while (bvalid !== 1'b1) step();
        r = bresp;
        @(posedge core_clk);
        bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        #1;
        while (arready !== 1'b1) step();
        @(posedge core_clk);
        arvalid <= 0;
        #1;
        while (rvalid !== 1'b1) step();
        d = rdata;
        r = rresp;
        @(posedge core_clk);
        rready <= 0;
    endtask
    // rate pins move only under reset, so both word counters restart together
    task reconf(input int n);
        @(posedge core_clk);
        reset <= 1;
        txr <= (n == 20);
        rxr <= (n == 20);
        repeat (2) @(posedge core_clk);
        check(rx_data_oe_n, 20'hFFFFF, "rx not floating again");
        check(32'(rx_par_clk), 0, "rx clock in second reset");
        reset <= 0;
    endtask
    task step;
        @(posedge core_clk);
        #1;
    endtask
    task fall_wait;
        while (rx_par_clk !== 1'b1) step();
        while (rx_par_clk !== 1'b0) step();
    endtask
    task t_reset;
        repeat (3) @(posedge core_clk);
        check(rx_data_oe_n, 20'hFFFFF, "rx not floating");
        check(32'(rx_par_clk), 0, "rx clock in reset");
        check(32'(tx_serial_oe_n), 1, "tx pin driven in reset");
        repeat (3) @(posedge core_clk);
        reset <= 0;
        $display("reset test done");
    endtask
    task t_regs;
        rd(OFS_CTRL);
        check(d, 0, "coder reset");
        rd(OFS_STAT);
        check(32'(d[1:0]), 3, "rate selects");
        wr(OFS_STAT, 32'hF);
        check(32'(r), 32'(RESP_OKAY), "ro write resp");
        rd(8'h0C);
        check({d[29:0], r}, 32'(RESP_SLVERR), "unmapped");
        $display("register test done");
    endtask
    // raw words both ways at rate n
    task t_bypass(input int n);
        int k;
        reconf(n);
        repeat (50) @(posedge core_clk);
        #1;
        while (tx_word_strobe !== 1'b1) step();
        for (int i = 0; i < n; i++)
        begin
            step();
            check(32'(tx_serial_out), 32'(next_word[i]), "tx bit");
            check(32'(tx_word_strobe), 32'(i == n - 1), "tx period");
        end
        fall_wait();
        check(rx_data_out, n == 20 ? hist : {10'h0, hist[19:10]}, "rx word");
        check(rx_data_oe_n, 0, "rx driven");
        k = 0;
        while (rx_par_clk !== 1'b1)
        begin
            step();
            k++;
        end
        check(k, n / 2, "rx clock low phase");
        $display("bypass test %0d done", n);
    endtask
    // coded loopback; high byte must vanish at half rate, bits 18/19 at both rates
    task t_coded(input int n, input logic [19:0] exp);
        @(posedge core_clk);
        loop <= 1;
        // high byte is plain data: a control flag on it names no legal code
        next_word <= 20'hD5ABC;
        reconf(n);
        wr(OFS_CTRL, 32'h1);
        repeat (300) @(posedge core_clk);
        #1;
        fall_wait();
        check(rx_data_out, exp, "decoded word");
        check(rx_data_oe_n, 20'hC0000, "upper bits float");
        rd(OFS_STAT);
        check(32'(d[3]), 1, "comma aligned");
        $display("coded test %0d done", n);
    endtask
    initial
    begin
        t_reset();
        t_regs();
        t_bypass(20);
        t_bypass(10);
        t_coded(20, 20'h15ABC);
        t_coded(10, 20'h100BC);
        finish_test();
    end
endmodule // tb
